// file: flmac_params.svh
// Offsets, field positions, reset values and constants of the flash lock block
`ifndef FLMAC_PARAMS_SVH
`define FLMAC_PARAMS_SVH
`define FLMAC_OFF_MEMORY_CONFIG_REG     12'h000
`define FLMAC_OFF_CPU_SYSTEM_REG     12'h004
`define FLMAC_OFF_MODE       12'h008
`define FLMAC_OFF_STATUS     12'h00c
`define FLMAC_OFF_CMD        12'h010
`define FLMAC_OFF_LADDR      12'h014
`define FLMAC_OFF_SCRATCH    12'h018
`define FLMAC_OFF_LINE       12'h020
`define FLMAC_OFF_LINE_END   12'h03c
`define FLMAC_CMD_ERASE      0
`define FLMAC_CMD_PROG       1
`define FLMAC_CMD_SETLOCK    2
`define FLMAC_CMD_SECTOR     8
`define FLMAC_ST_CODE_LK     0
`define FLMAC_ST_CFG_LK      1
`define FLMAC_ST_PENDING     2
`define FLMAC_ST_DENIED      3
`define FLMAC_ST_DBG_REF     4
`define FLMAC_MEMORY_CONFIG_REG_RST     5'h00
`define FLMAC_PAGE_RST       2'h0
`define FLMAC_PAGE_COUNT     2'h3
`define FLMAC_LOCK_PATTERN   8'h69
`define FLMAC_LOCK_DISABLED  8'h00
`define FLMAC_LOCK_MAXDIST   4'h3
`define FLMAC_SHARED_BASE    8'h80
`define FLMAC_CPU_SYSTEM_REG_ADDR    8'hb0
`define FLMAC_SCRATCH_BASE   16'haff8
`define FLMAC_SCRATCH_CNT    16'h0003
`define FLMAC_LAST_LINE      3'h7
`endif

// file: flmac_pkg.sv
// Types shared by the flash lock and memory access block
package flmac_pkg;
    typedef enum logic [1:0] {FLMAC_NORMAL, FLMAC_PROGRAM, FLMAC_DEBUG} flmac_mode_t;
    typedef enum logic [0:0] {FLMAC_CODE, FLMAC_CFG} flmac_sector_t;
    typedef enum logic [1:0] {FLMAC_READ, FLMAC_WRITE, FLMAC_ERASE} flmac_op_t;
    typedef enum logic [2:0] {FLMAC_RUN, FLMAC_IDLE, FLMAC_DEEP_IDLE, FLMAC_POWER_DOWN, FLMAC_TX_LOW} flmac_pwr_t;
    typedef struct packed {
        logic          valid;
        flmac_sector_t sector;
        flmac_op_t     op;
    } flmac_acc_t;
    typedef struct packed {
        logic       sfr;
        logic       ram;
        logic       cpu_system_reg;
        logic       blocked;
        logic [1:0] page;
    } flmac_dsel_t;
    typedef struct packed {
        logic          erase;
        logic          prog;
        logic          set_lock;
        flmac_sector_t sector;
        logic [2:0]    line;
    } flmac_fcmd_t;
endpackage : flmac_pkg

// file: flmac_top.sv
// Flash lock evaluation, access control and memory decode with APB registers
//
// Function
// - Last byte of each flash sector is a lock byte guarding write and read
// - Lock byte holding 0x69 counts as enabled
// - Lock byte within Hamming distance three of 0x69 also counts as enabled
// - Config lock acts only when code lock is enabled; code lock wins
// - New lock byte values take effect only after the next reset
// - Debug mode entry refused while code lock is in effect
// - Both locks clear: read, write, erase allowed in normal and program mode
// - Code lock only, normal mode: code write denied, config fully open
// - Both locks, normal mode: writes denied, reads allowed, code erase allowed
// - Program mode: locked sectors deny read and write
// - Program mode accepts sector erase and 32-byte line program commands
// - Program-mode command sets config lock; none exists for the code lock
// - Runtime write of 0x69 to config last byte enables config lock
// - Five 32-byte retention blocks, each powered when its enable bit is set
// - Enabled retention blocks keep contents in all states while battery stays
// - Shared 0x80-0xff: direct goes to special registers, indirect to RAM
// - Three special register pages chosen by two bits visible on all pages
// - Upper 128 RAM bytes belong to the radio engine during transmission
// - RAM unpowered in power-down and deep idle; lower bank off in TX low power
// - Three scratch RAM bytes mapped into code space from 0xaff8
// - Retention registers kept; factory-loaded ones reloaded on every wake-up
`include "flmac_params.svh"

module flmac_top #(
    parameter int RET_BLOCKS = 5,
    parameter int LINE_WORDS = 8
) (
    // APB slave
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    // Lock bytes as read from flash
    input  wire logic [7:0]           code_sector_lock,
    input  wire logic [7:0]           config_sector_lock,
    // CPU flash access check
    input  wire flmac_pkg::flmac_acc_t cpu_acc,
    output logic                      cpu_acc_grant,
    // Flash command out
    output flmac_pkg::flmac_fcmd_t    flash_cmd,
    output logic [32*LINE_WORDS-1:0]  flash_line_data,
    // Data memory decode
    input  wire logic                 dmem_valid,
    input  wire logic [7:0]           dmem_addr,
    input  wire logic                 dmem_indirect,
    input  wire logic                 tx_active,
    output flmac_pkg::flmac_dsel_t    dmem_sel,
    // Power control
    input  wire flmac_pkg::flmac_pwr_t pwr_state,
    output logic                      ram_lower_pwr,
    output logic                      ram_upper_pwr,
    output logic [RET_BLOCKS-1:0]     ret_block_pwr,
    // Code space scratch bytes
    input  wire logic [15:0]          code_addr,
    output logic                      code_scratch_hit,
    output logic [7:0]                code_scratch_data,
    // Wake-up refresh
    input  wire logic                 wake_evt,
    output logic                      factory_reload
);

    ////////////////////////////////////////////////////////////////////////////
    // Lock byte evaluation

    function automatic logic lock_on(input logic [7:0] b);
        logic [7:0] d;
        logic [3:0] n;
        d = b ^ `FLMAC_LOCK_PATTERN;
        n = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            n = n + {3'h0, d[i]};
        end
        return n <= `FLMAC_LOCK_MAXDIST;
    endfunction : lock_on

    function automatic logic allowed(input flmac_pkg::flmac_mode_t m, input logic clk_lk,
                                     input logic cfg_lk, input flmac_pkg::flmac_acc_t a);
        logic lk;
        lk = (a.sector == flmac_pkg::FLMAC_CODE) ? clk_lk : cfg_lk;
        unique case (a.op)
            flmac_pkg::FLMAC_READ:  return (m == flmac_pkg::FLMAC_NORMAL) || !lk;
            flmac_pkg::FLMAC_WRITE: return !lk;
            flmac_pkg::FLMAC_ERASE: return (a.sector == flmac_pkg::FLMAC_CODE)
                                           || (m != flmac_pkg::FLMAC_NORMAL) || !lk;
            default:                return 1'b0;
        endcase
    endfunction : allowed

    logic sampled_q;
    logic code_lk_q;
    logic cfg_raw_q;
    logic cfg_lk;

    // Locked until sampled so nothing leaks in the first cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sampled_q <= 1'b0;
            code_lk_q <= 1'b1;
            cfg_raw_q <= 1'b1;
        end
        else if (!sampled_q)
        begin
            sampled_q <= 1'b1;
            code_lk_q <= lock_on(code_sector_lock);
            cfg_raw_q <= lock_on(config_sector_lock);
        end
    end

    assign cfg_lk = cfg_raw_q && code_lk_q;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    logic [11:0] off;

    assign off    = {paddr[11:2], 2'b00};
    assign mapped = (off <= `FLMAC_OFF_SCRATCH) || (off >= `FLMAC_OFF_LINE && off <= `FLMAC_OFF_LINE_END);
    assign wr_en  = psel && penable && pwrite && mapped;
    assign rd_en  = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    ////////////////////////////////////////////////////////////////////////////
    // Software registers

    logic [RET_BLOCKS-1:0]   ret_en_q;
    logic [1:0]              page_q;
    flmac_pkg::flmac_mode_t  mode_q;
    logic                    dbg_ref_q;
    logic                    denied_q;
    logic                    pending_q;
    logic [2:0]              laddr_q;
    logic [23:0]             scratch_q;
    logic [31:0]             line_q [LINE_WORDS];

    // Retention enables survive everything but the device reset itself
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ret_en_q <= RET_BLOCKS'(`FLMAC_MEMORY_CONFIG_REG_RST);
        else if (wr_en && off == `FLMAC_OFF_MEMORY_CONFIG_REG)
            ret_en_q <= pwdata[RET_BLOCKS-1:0];
    end

    assign ret_block_pwr = ret_en_q;

    // Page code three does not exist and is ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            page_q <= `FLMAC_PAGE_RST;
        else if (wr_en && off == `FLMAC_OFF_CPU_SYSTEM_REG && pwdata[1:0] < `FLMAC_PAGE_COUNT)
            page_q <= pwdata[1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q    <= flmac_pkg::FLMAC_NORMAL;
            dbg_ref_q <= 1'b0;
        end
        else if (wr_en && off == `FLMAC_OFF_MODE)
        begin
            if (pwdata[1:0] == 2'h2 && code_lk_q)
                dbg_ref_q <= 1'b1;
            else if (pwdata[1:0] < 2'h3)
            begin
                mode_q    <= flmac_pkg::flmac_mode_t'(pwdata[1:0]);
                dbg_ref_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            laddr_q   <= 3'h0;
            scratch_q <= 24'h000000;
        end
        else if (wr_en && off == `FLMAC_OFF_LADDR)
            laddr_q <= pwdata[2:0];
        else if (wr_en && off == `FLMAC_OFF_SCRATCH)
            scratch_q <= pwdata[23:0];
    end

    // Line buffer holds the 32-byte line to be programmed
    generate
        for (genvar w = 0; w < LINE_WORDS; w++)
        begin : g_line
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    line_q[w] <= 32'h00000000;
                else if (wr_en && off == `FLMAC_OFF_LINE + 12'(4 * w))
                    line_q[w] <= pwdata;
            end
            assign flash_line_data[32*w +: 32] = line_q[w];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Flash commands

    flmac_pkg::flmac_acc_t  cmd_acc;
    logic                   cmd_wr;
    logic                   cmd_ok;
    logic                   cmd_any;
    logic                   lock_byte_set;

    assign cmd_wr  = wr_en && off == `FLMAC_OFF_CMD;
    assign cmd_any = pwdata[`FLMAC_CMD_ERASE] || pwdata[`FLMAC_CMD_PROG] || pwdata[`FLMAC_CMD_SETLOCK];
    assign cmd_acc.valid  = cmd_wr;
    assign cmd_acc.sector = flmac_pkg::flmac_sector_t'(pwdata[`FLMAC_CMD_SECTOR]);
    assign cmd_acc.op     = pwdata[`FLMAC_CMD_ERASE] ? flmac_pkg::FLMAC_ERASE : flmac_pkg::FLMAC_WRITE;
    assign lock_byte_set  = laddr_q == `FLMAC_LAST_LINE && line_q[LINE_WORDS-1][31:24] == `FLMAC_LOCK_PATTERN;

    // Program mode takes any; runtime only reaches the config sector
    always_comb
    begin
        if (pwdata[`FLMAC_CMD_SETLOCK])
            cmd_ok = mode_q == flmac_pkg::FLMAC_PROGRAM && !cfg_lk;
        else if (mode_q == flmac_pkg::FLMAC_PROGRAM)
            cmd_ok = allowed(mode_q, code_lk_q, cfg_lk, cmd_acc);
        else
            cmd_ok = cmd_acc.sector == flmac_pkg::FLMAC_CFG && allowed(mode_q, code_lk_q, cfg_lk, cmd_acc);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flash_cmd <= '0;
        else
        begin
            flash_cmd.erase    <= cmd_wr && cmd_ok && pwdata[`FLMAC_CMD_ERASE];
            flash_cmd.prog     <= cmd_wr && cmd_ok && !pwdata[`FLMAC_CMD_ERASE] && pwdata[`FLMAC_CMD_PROG];
            flash_cmd.set_lock <= cmd_wr && cmd_ok && pwdata[`FLMAC_CMD_SETLOCK]
                                  && !pwdata[`FLMAC_CMD_ERASE] && !pwdata[`FLMAC_CMD_PROG];
            flash_cmd.sector   <= cmd_acc.sector;
            flash_cmd.line     <= laddr_q;
        end
    end

    // Sticky flags; hardware set beats software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            denied_q  <= 1'b0;
            pending_q <= 1'b0;
        end
        else
        begin
            if (cmd_wr && cmd_any && !cmd_ok)
                denied_q <= 1'b1;
            else if (wr_en && off == `FLMAC_OFF_STATUS && pwdata[`FLMAC_ST_DENIED])
                denied_q <= 1'b0;
            if (cmd_wr && cmd_ok && pwdata[`FLMAC_CMD_SETLOCK])
                pending_q <= 1'b1;
            else if (cmd_wr && cmd_ok && pwdata[`FLMAC_CMD_PROG] && cmd_acc.sector == flmac_pkg::FLMAC_CFG
                     && lock_byte_set)
                pending_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_en)
        begin
            prdata <= 32'h00000000;
            if (off == `FLMAC_OFF_MEMORY_CONFIG_REG)
                prdata[RET_BLOCKS-1:0] <= ret_en_q;
            else if (off == `FLMAC_OFF_CPU_SYSTEM_REG)
                prdata[1:0] <= page_q;
            else if (off == `FLMAC_OFF_MODE)
                prdata[1:0] <= mode_q;
            else if (off == `FLMAC_OFF_STATUS)
                prdata[4:0] <= {dbg_ref_q, denied_q, pending_q, cfg_lk, code_lk_q};
            else if (off == `FLMAC_OFF_LADDR)
                prdata[2:0] <= laddr_q;
            else if (off == `FLMAC_OFF_SCRATCH)
                prdata[23:0] <= scratch_q;
            else if (off >= `FLMAC_OFF_LINE && off <= `FLMAC_OFF_LINE_END)
                prdata <= line_q[off[4:2]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU access, data memory and power

    assign cpu_acc_grant = cpu_acc.valid && sampled_q
                           && allowed(mode_q, code_lk_q, cfg_lk, cpu_acc);

    logic upper;
    assign upper = dmem_addr >= `FLMAC_SHARED_BASE;

    assign ram_upper_pwr = !(pwr_state == flmac_pkg::FLMAC_POWER_DOWN
                             || pwr_state == flmac_pkg::FLMAC_DEEP_IDLE);
    assign ram_lower_pwr = ram_upper_pwr && pwr_state != flmac_pkg::FLMAC_TX_LOW;

    always_comb
    begin
        dmem_sel.sfr     = dmem_valid && upper && !dmem_indirect;
        dmem_sel.blocked = dmem_valid && upper && dmem_indirect && tx_active;
        dmem_sel.ram     = dmem_valid && (!upper || dmem_indirect) && !dmem_sel.blocked
                           && (upper ? ram_upper_pwr : ram_lower_pwr);
        dmem_sel.cpu_system_reg  = dmem_sel.sfr && dmem_addr == `FLMAC_CPU_SYSTEM_REG_ADDR;
        dmem_sel.page    = page_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Code space scratch and wake refresh

    logic [15:0] sidx;
    assign sidx = code_addr - `FLMAC_SCRATCH_BASE;
    assign code_scratch_hit = code_addr >= `FLMAC_SCRATCH_BASE && sidx < `FLMAC_SCRATCH_CNT;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            code_scratch_data <= 8'h00;
            factory_reload    <= 1'b0;
        end
        else
        begin
            code_scratch_data <= code_scratch_hit ? scratch_q[8*sidx[1:0] +: 8] : 8'h00;
            factory_reload    <= wake_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_lock_sample: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sampled_q) |-> code_lk_q == lock_on($past(code_sector_lock)))
        else $error("code lock not evaluated at reset");
    chk_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
        sampled_q && $past(sampled_q) |-> $stable(code_lk_q) && $stable(cfg_raw_q))
        else $error("lock state changed without reset");
    chk_cfg_priority: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_lk |-> code_lk_q)
        else $error("config lock effective without code lock");
    chk_debug_refused: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && off == `FLMAC_OFF_MODE && pwdata[1:0] == 2'h2 && code_lk_q
        |=> mode_q == $past(mode_q) && dbg_ref_q)
        else $error("debug entered while code locked");
    chk_code_write: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_acc.valid && cpu_acc.op == flmac_pkg::FLMAC_WRITE && cpu_acc.sector == flmac_pkg::FLMAC_CODE
        && code_lk_q |-> !cpu_acc_grant)
        else $error("write to locked code sector granted");
    chk_cmd_denied: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && cmd_any && !cmd_ok |=> !flash_cmd.erase && !flash_cmd.prog && denied_q)
        else $error("denied command reached flash");
    chk_tx_ram: assert property (@(posedge pclk) disable iff (!presetn)
        tx_active && dmem_valid && dmem_indirect && upper |-> !dmem_sel.ram)
        else $error("upper RAM reached during transmission");
    chk_ram_power: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_state == flmac_pkg::FLMAC_TX_LOW |-> !ram_lower_pwr && ram_upper_pwr)
        else $error("wrong RAM power in TX low power");
    chk_wake_reload: assert property (@(posedge pclk) disable iff (!presetn)
        wake_evt |=> factory_reload ##1 (factory_reload == $past(wake_evt)))
        else $error("reload pulse missing after wake");
    chk_scratch_map: assert property (@(posedge pclk) disable iff (!presetn)
        code_addr == `FLMAC_SCRATCH_BASE + 16'h0002 |=> code_scratch_data == scratch_q[23:16]
        || $changed(scratch_q))
        else $error("scratch byte mapping wrong");

endmodule : flmac_top

// file: flmac_flash_model.sv
// Flash array model that stores both lock bytes and obeys the block's flash commands
`include "flmac_params.svh"
module flmac_flash_model #(
    parameter int LW = 8
) (
    // Clock and bench preload
    input  wire logic                   pclk,
    input  wire logic                   preload,
    input  wire logic [7:0]             pre_code,
    input  wire logic [7:0]             pre_cfg,
    // Commands from the block
    input  wire flmac_pkg::flmac_fcmd_t flash_cmd,
    input  wire logic [32*LW-1:0]       flash_line_data,
    // Stored lock bytes
    output logic [7:0]                  code_sector_lock,
    output logic [7:0]                  config_sector_lock
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    // Flash cells survive device reset; erased cells read as a disabled lock
    always_ff @(posedge pclk)
    begin
        if (preload)
        begin
            code_sector_lock   <= pre_code;
            config_sector_lock <= pre_cfg;
        end
        else if (flash_cmd.erase && flash_cmd.sector == flmac_pkg::FLMAC_CODE)
            code_sector_lock <= `FLMAC_LOCK_DISABLED;
        else if (flash_cmd.erase)
            config_sector_lock <= `FLMAC_LOCK_DISABLED;
        else if (flash_cmd.prog && flash_cmd.line == `FLMAC_LAST_LINE && flash_cmd.sector == flmac_pkg::FLMAC_CODE)
            code_sector_lock <= flash_line_data[32*LW-1 -: 8];
        else if (flash_cmd.prog && flash_cmd.line == `FLMAC_LAST_LINE)
            config_sector_lock <= flash_line_data[32*LW-1 -: 8];
        else if (flash_cmd.set_lock)
            config_sector_lock <= `FLMAC_LOCK_PATTERN;
    end
endmodule : flmac_flash_model

// file: flmac_top_test.sv
// Self-checking testbench of the flash lock and memory access block
`include "flmac_params.svh"
module flmac_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic psel, penable, pwrite, pready, pslverr, cpu_acc_grant, preload, dmem_valid, dmem_indirect, tx_active;
    logic pclk, presetn, ram_lower_pwr, ram_upper_pwr, code_scratch_hit, wake_evt, factory_reload, err;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, q;
    logic [7:0]             code_sector_lock, config_sector_lock, pre_code, pre_cfg, code_scratch_data, dmem_addr;
    logic [15:0]            code_addr;
    logic [4:0]             ret_block_pwr;
    logic [255:0]           flash_line_data;
    flmac_pkg::flmac_acc_t  cpu_acc;
    flmac_pkg::flmac_fcmd_t flash_cmd;
    flmac_pkg::flmac_dsel_t dmem_sel;
    flmac_pkg::flmac_pwr_t  pwr_state;
    int                     mismatches = 0;
    int                     tests_run = 0;

    flmac_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .code_sector_lock, .config_sector_lock, .cpu_acc, .cpu_acc_grant, .flash_cmd, .flash_line_data,
        .dmem_valid, .dmem_addr, .dmem_indirect, .tx_active, .dmem_sel, .pwr_state, .ram_lower_pwr,
        .ram_upper_pwr, .ret_block_pwr, .code_addr, .code_scratch_hit, .code_scratch_data, .wake_evt,
        .factory_reload);
    flmac_flash_model flash (.pclk, .preload, .pre_code, .pre_cfg, .flash_cmd, .flash_line_data,
        .code_sector_lock, .config_sector_lock);

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s got %0h wanted %0h", $time, msg, got, exp);
        end
    endtask : chk

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Lock bytes load into flash when pl is set, then a full reset lets the block sample them
    task automatic rst_with(input logic [7:0] c, input logic [7:0] g, input logic pl);
        preload  <= pl;
        pre_code <= c;
        pre_cfg  <= g;
        @(posedge pclk);
        preload <= 1'b0;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : rst_with

    function automatic logic exp_grant(logic ck, logic cg, logic pm, int s, int o);
        logic lk;
        lk = (s == 1) ? (ck & cg) : ck;
        return (o == 0) ? (!pm || !lk) : (o == 1) ? !lk : (s == 0 || pm || !lk);
    endfunction : exp_grant

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_locks;
        logic [7:0] v [4] = '{8'h69, 8'h6e, 8'h66, 8'h00};
        logic       e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 4; i++)
        begin
            rst_with(v[i], `FLMAC_LOCK_PATTERN, 1'b1);
            apb(1'b0, `FLMAC_OFF_STATUS, 32'h0);
            chk(q[`FLMAC_ST_CODE_LK], e[i], "code lock");
            chk(q[`FLMAC_ST_CFG_LK], e[i], "config lock");
        end
    endtask : t_locks

    task automatic t_access;
        for (int lk = 0; lk < 3; lk++)
        begin
            rst_with((lk > 0) ? 8'h69 : 8'h00, (lk == 2) ? 8'h69 : 8'h00, 1'b1);
            for (int pm = 0; pm < 2; pm++)
            begin
                apb(1'b1, `FLMAC_OFF_MODE, 32'(pm));
                for (int k = 0; k < 6; k++)
                begin
                    @(posedge pclk);
                    cpu_acc <= {1'b1, 1'(k / 3), 2'(k % 3)};
                    @(negedge pclk);
                    chk(cpu_acc_grant, exp_grant(lk > 0, lk == 2, pm[0], k / 3, k % 3), "grant");
                end
            end
        end
    endtask : t_access

    task automatic t_debug;
        rst_with(8'h69, 8'h00, 1'b1);
        apb(1'b1, `FLMAC_OFF_MODE, 32'h2);
        apb(1'b0, `FLMAC_OFF_MODE, 32'h0);
        chk(q, 32'h0, "debug entry while locked");
        apb(1'b0, `FLMAC_OFF_STATUS, 32'h0);
        chk(q[`FLMAC_ST_DBG_REF], 1'b1, "debug refusal flag");
        rst_with(8'h00, 8'h00, 1'b1);
        apb(1'b1, `FLMAC_OFF_MODE, 32'h2);
        apb(1'b0, `FLMAC_OFF_MODE, 32'h0);
        chk(q, 32'h2, "debug entry unlocked");
    endtask : t_debug

    // Issue a command and look at the one-cycle pulse that follows the write edge
    task automatic cmd(input logic [31:0] c, input logic [4:0] exp);
        apb(1'b1, `FLMAC_OFF_CMD, c);
        @(negedge pclk);
        chk({flash_cmd.erase, flash_cmd.prog, flash_cmd.set_lock, flash_cmd.sector, flash_cmd.line[0]}, exp, "cmd");
    endtask : cmd

    task automatic t_program;
        rst_with(8'h00, 8'h00, 1'b1);
        for (int w = 0; w < 8; w++)
            apb(1'b1, 12'(`FLMAC_OFF_LINE + 4 * w), (w == 7) ? 32'h6900_0000 : 32'h0);
        apb(1'b1, `FLMAC_OFF_LADDR, 32'h7);
        cmd(32'h102, 5'b01011);
        apb(1'b0, `FLMAC_OFF_STATUS, 32'h0);
        chk(q[`FLMAC_ST_PENDING], 1'b1, "runtime config lock intent");
        apb(1'b1, `FLMAC_OFF_MODE, 32'h1);
        cmd(32'h002, 5'b01001);
        cmd(32'h004, 5'b00101);
        apb(1'b0, `FLMAC_OFF_STATUS, 32'h0);
        chk(q[`FLMAC_ST_CODE_LK], 1'b0, "lock before reset");
        rst_with(8'h00, 8'h00, 1'b0);
        apb(1'b0, `FLMAC_OFF_STATUS, 32'h0);
        chk(q[`FLMAC_ST_CODE_LK], 1'b1, "lock after reset");
        apb(1'b1, `FLMAC_OFF_MODE, 32'h1);
        cmd(32'h002, 5'b00000);
        apb(1'b0, `FLMAC_OFF_STATUS, 32'h0);
        chk(q[`FLMAC_ST_DENIED], 1'b1, "denied program");
        cmd(32'h004, 5'b00000);
        cmd(32'h001, 5'b10000);
    endtask : t_program

    task automatic dm(input logic ind, input logic [7:0] a, input logic tx, input logic [5:0] exp);
        @(posedge pclk);
        dmem_valid    <= 1'b1;
        dmem_indirect <= ind;
        dmem_addr     <= a;
        tx_active     <= tx;
        @(negedge pclk);
        chk(dmem_sel, exp, "decode");
    endtask : dm

    task automatic t_memory;
        logic [1:0] rp [5] = '{2'b11, 2'b11, 2'b00, 2'b00, 2'b01};
        apb(1'b1, `FLMAC_OFF_CPU_SYSTEM_REG, 32'h2);
        apb(1'b1, `FLMAC_OFF_CPU_SYSTEM_REG, 32'h3);
        dm(1'b0, `FLMAC_CPU_SYSTEM_REG_ADDR, 1'b0, 6'b101010);
        dm(1'b1, 8'h90, 1'b0, 6'b010010);
        dm(1'b1, 8'h90, 1'b1, 6'b000110);
        dm(1'b0, 8'h10, 1'b1, 6'b010010);
        apb(1'b1, `FLMAC_OFF_MEMORY_CONFIG_REG, 32'h15);
        for (int s = 0; s < 5; s++)
        begin
            @(posedge pclk);
            pwr_state <= flmac_pkg::flmac_pwr_t'(s);
            @(negedge pclk);
            chk({ram_lower_pwr, ram_upper_pwr}, rp[s], "ram power");
            chk(ret_block_pwr, 5'h15, "retention power");
        end
        apb(1'b1, `FLMAC_OFF_SCRATCH, 32'h0033_2211);
        pwr_state <= flmac_pkg::FLMAC_RUN;
        code_addr <= 16'haff9;
        @(negedge pclk);
        chk(code_scratch_hit, 1'b1, "scratch hit");
        @(posedge pclk);
        code_addr <= 16'haffb;
        wake_evt  <= 1'b1;
        @(negedge pclk);
        chk(code_scratch_data, 8'h22, "scratch data");
        chk(code_scratch_hit, 1'b0, "scratch end");
        @(posedge pclk);
        wake_evt <= 1'b0;
        @(negedge pclk);
        chk(factory_reload, 1'b1, "reload after wake");
        apb(1'b0, 12'h01c, 32'h0);
        chk(err, 1'b1, "unmapped error");
        chk(q, 32'h0, "unmapped read");
    endtask : t_memory

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, cpu_acc, dmem_valid, dmem_addr, dmem_indirect} = '0;
        {tx_active, code_addr, wake_evt, presetn, preload, pre_code, pre_cfg} = '0;
        pwr_state = flmac_pkg::FLMAC_RUN;
        t_locks();
        t_access();
        t_debug();
        t_program();
        t_memory();
        complete_run();
    end

    // A hang counts as a failure
    initial
    begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        complete_run();
    end
endmodule : flmac_top_test
